// file: ar_pkg.sv
// Constants, types and register map of the auto-reclose sequencer
package reclose_pkg;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TICK_PERIOD_NS = 1_000_000;
    localparam int unsigned TICK_W = 24;
    localparam int unsigned TMR_W = 16;

    // Cycle limits
    localparam int unsigned NUM_SETS = 4;
    localparam int unsigned MAX_CYCLES = 8;

    // Register byte offsets, cycle block numbers and field indices
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_SEQ_DEAD = 8'h10;
    localparam logic [3:0] CYC_FIRST_BLK = 4'h2;
    localparam logic [3:0] CYC_LAST_BLK = 4'h5;
    localparam logic [1:0] FLD_DEAD_1P = 2'h0;
    localparam logic [1:0] FLD_DEAD_3P = 2'h1;
    localparam logic [1:0] FLD_RECLAIM = 2'h2;
    localparam logic [1:0] FLD_ACTION = 2'h3;

    // Field positions
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_CYC_LSB = 1;
    localparam int unsigned CTRL_FORCE3P = 4;
    localparam int unsigned CTRL_SEQ_PICKUP = 5;
    localparam int unsigned CTRL_SEQ_3P = 6;
    localparam int unsigned CTRL_RELEASE = 7;
    localparam int unsigned CFG_ALLOW1P = 16;
    localparam int unsigned CFG_ALLOW3P = 17;
    localparam int unsigned STAT_CYC_LSB = 8;
    localparam int unsigned STAT_BLOCK = 12;
    localparam int unsigned STAT_NOT_READY = 13;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_CLOSE = 0;
    localparam int unsigned IRQ_SUCCESS = 1;
    localparam int unsigned IRQ_FINAL = 2;
    localparam int unsigned IRQ_SEQ = 3;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
    localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;

    typedef enum logic [5:0] {
        S_IDLE = 6'b00_0001,
        S_TRIPPED = 6'b00_0010,
        S_DEAD = 6'b00_0100,
        S_SEQ_WAIT = 6'b00_1000,
        S_RECLAIM = 6'b01_0000,
        S_BLOCKED = 6'b10_0000
    } state_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic trip_1p;
        logic trip_3p;
        logic pickup;
        logic [2:0] pole_closed;
        logic [3:0] cycle_block;
    } pins_t;

    typedef struct packed {
        logic [TMR_W-1:0] dead_1p;
        logic [TMR_W-1:0] dead_3p;
        logic [TMR_W-1:0] reclaim;
        logic [TMR_W-1:0] action;
        logic allow_1p;
        logic allow_3p;
    } cycle_cfg_t;

endpackage : reclose_pkg

// file: auto_reclose_sequencer.sv
// Auto-reclose sequencer with Wishbone register slave
module auto_reclose_sequencer #(
    parameter int unsigned TICK_CYCLES =
        reclose_pkg::TICK_PERIOD_NS / reclose_pkg::CLK_PERIOD_NS
) (
    // Clock, reset, enable
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    // Wishbone slave
    input wire reclose_pkg::wb_req_t WB_REQ,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Protection and breaker pins
    input wire reclose_pkg::pins_t PINS,
    // Commands and interrupt
    output logic CLOSE_CMD,
    output logic TRIP_3P_CMD,
    output logic NOT_READY,
    output logic IRQ
);
    import reclose_pkg::*;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Cycles past the fourth share the fourth set
    function automatic logic [1:0] set_index(input logic [3:0] cnt);
        return (cnt >= 4'(NUM_SETS - 1)) ? 2'(NUM_SETS - 1) : cnt[1:0];
    endfunction : set_index

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    pins_t pin_meta;
    pins_t pin_s;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            pin_meta <= '0;
            pin_s <= '0;
        end else if (CE) begin
            pin_meta <= PINS;
            pin_s <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timebase

    logic [TICK_W-1:0] tick_cnt;
    wire tick = (tick_cnt == TICK_LAST);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tick_cnt <= '0;
        end else if (CE) begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [31:0] ctrl;
    logic [TMR_W-1:0] seq_dead;
    cycle_cfg_t cfg [NUM_SETS];
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0] rd_data;
    state_t state;
    logic [3:0] cycle_cnt;

    wire acc = WB_REQ.cyc & WB_REQ.stb;
    wire wr = acc & WB_REQ.we & WB_ACK_O;
    wire [7:0] adr = {WB_REQ.adr[7:2], 2'b00};
    wire [3:0] blk = adr[7:4];
    wire cfg_hit = (blk >= CYC_FIRST_BLK) && (blk <= CYC_LAST_BLK);
    wire [1:0] slot = 2'(blk - CYC_FIRST_BLK);
    wire [1:0] field = adr[3:2];
    wire wr_ctrl = wr && (adr == REG_CTRL);
    wire [31:0] ctrl_new = merge(ctrl, WB_REQ.dat, WB_REQ.sel);
    wire [31:0] irq_clr = merge('0, WB_REQ.dat, WB_REQ.sel);
    wire [31:0] mask_new = merge(32'(irq_mask), WB_REQ.dat, WB_REQ.sel);
    wire [31:0] sdt_new = merge(32'(seq_dead), WB_REQ.dat, WB_REQ.sel);

    // Release is a write-one pulse, never stored
    wire block_release = wr_ctrl & ctrl_new[CTRL_RELEASE];

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else if (CE) begin
            WB_ACK_O <= acc & ~WB_ACK_O;
            WB_DAT_O <= rd_data;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ctrl <= CTRL_RST;
            irq_mask <= MASK_RST;
            seq_dead <= TMR_RST;
        end else if (CE && wr) begin
            if (adr == REG_CTRL) begin
                ctrl <= ctrl_new & ~(32'h0000_0001 << CTRL_RELEASE);
            end
            if (adr == REG_IRQ_MASK) begin
                irq_mask <= mask_new[IRQ_W-1:0];
            end
            if (adr == REG_SEQ_DEAD) begin
                seq_dead <= sdt_new[TMR_W-1:0];
            end
        end
    end

    genvar k;
    generate
        for (k = 0; k < NUM_SETS; k++) begin : g_cfg
            wire hit = wr && cfg_hit && (slot == 2'(k));
            wire [31:0] fld_old =
                (field == FLD_DEAD_1P) ? 32'(cfg[k].dead_1p) :
                (field == FLD_DEAD_3P) ? 32'(cfg[k].dead_3p) :
                (field == FLD_RECLAIM) ? 32'(cfg[k].reclaim) :
                {14'h0000, cfg[k].allow_3p, cfg[k].allow_1p,
                 cfg[k].action};
            wire [31:0] fld_new = merge(fld_old, WB_REQ.dat, WB_REQ.sel);
            // Each of the first four cycles keeps its own set
            always_ff @(posedge REF_CLK) begin
                if (RST) begin
                    cfg[k] <= '0;
                end else if (CE && hit) begin
                    case (field)
                        FLD_DEAD_1P: cfg[k].dead_1p <= fld_new[TMR_W-1:0];
                        FLD_DEAD_3P: cfg[k].dead_3p <= fld_new[TMR_W-1:0];
                        FLD_RECLAIM: cfg[k].reclaim <= fld_new[TMR_W-1:0];
                        default: begin
                            cfg[k].action <= fld_new[TMR_W-1:0];
                            cfg[k].allow_1p <= fld_new[CFG_ALLOW1P];
                            cfg[k].allow_3p <= fld_new[CFG_ALLOW3P];
                        end
                    endcase
                end
            end
        end
    endgenerate

    wire [31:0] status_word = {18'h0_0000, NOT_READY,
        (state == S_BLOCKED), cycle_cnt, 2'b00, state};
    wire [31:0] cfg_word =
        (field == FLD_DEAD_1P) ? 32'(cfg[slot].dead_1p) :
        (field == FLD_DEAD_3P) ? 32'(cfg[slot].dead_3p) :
        (field == FLD_RECLAIM) ? 32'(cfg[slot].reclaim) :
        {14'h0000, cfg[slot].allow_3p, cfg[slot].allow_1p,
         cfg[slot].action};

    // Unmapped addresses read zero and still acknowledge
    assign rd_data =
        (adr == REG_CTRL) ? ctrl :
        (adr == REG_STATUS) ? status_word :
        (adr == REG_IRQ_STAT) ? 32'(irq_stat) :
        (adr == REG_IRQ_MASK) ? 32'(irq_mask) :
        (adr == REG_SEQ_DEAD) ? 32'(seq_dead) :
        cfg_hit ? cfg_word : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Decoded conditions

    wire reclose_en = ctrl[CTRL_EN];
    wire [3:0] max_cyc = {1'b0, ctrl[CTRL_CYC_LSB +: 3]} + 4'h1;
    wire force3p = ctrl[CTRL_FORCE3P];
    wire seq_pick = ctrl[CTRL_SEQ_PICKUP];
    wire seq_3p = ctrl[CTRL_SEQ_3P];

    wire [1:0] idx = set_index(cycle_cnt);
    cycle_cfg_t cur;
    assign cur = cfg[idx];
    wire blocked_in = pin_s.cycle_block[idx];

    wire trip_any = pin_s.trip_1p | pin_s.trip_3p;
    wire trip_is_1p = pin_s.trip_1p & ~pin_s.trip_3p;
    wire all_closed = &pin_s.pole_closed;
    wire any_open = ~all_closed;
    wire all_open = ~|pin_s.pole_closed;
    wire perm = trip_is_1p ? cur.allow_1p : cur.allow_3p;
    wire last_done = (cycle_cnt >= max_cyc);
    wire ready = reclose_en & all_closed;

    logic seq_det_q;
    wire seq_det = seq_pick ? pin_s.pickup : trip_any;
    wire seq_rise = seq_det & ~seq_det_q;

    ////////////////////////////////////////////////////////////////////////
    // Action time supervision

    logic [TMR_W-1:0] act_tmr;
    logic act_armed;
    logic pickup_q;
    wire pickup_rise = pin_s.pickup & ~pickup_q;
    // A zero action time means no supervision
    wire act_late = act_armed && (act_tmr == TMR_RST)
                    && (cur.action != TMR_RST);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            act_tmr <= TMR_RST;
            act_armed <= 1'b0;
            pickup_q <= 1'b0;
            seq_det_q <= 1'b0;
        end else if (CE) begin
            pickup_q <= pin_s.pickup;
            seq_det_q <= seq_det;
            if (pickup_rise) begin
                act_tmr <= cur.action;
                act_armed <= 1'b1;
            end else if (!pin_s.pickup) begin
                act_armed <= 1'b0;
            end else if (tick && act_tmr != TMR_RST) begin
                act_tmr <= act_tmr - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    logic one_pole;
    logic cleared;
    logic [TMR_W-1:0] dead_tmr;
    logic [TMR_W-1:0] rec_tmr;
    state_t next_state;
    logic [3:0] next_cycle;
    logic next_one_pole;
    logic next_cleared;
    logic [TMR_W-1:0] next_dead;
    logic [TMR_W-1:0] next_rec;
    logic next_close;
    logic next_trip3p;
    logic [IRQ_W-1:0] ev;

    always_comb begin
        next_state = state;
        next_cycle = cycle_cnt;
        next_one_pole = one_pole;
        next_cleared = cleared;
        next_dead = (tick && dead_tmr != TMR_RST) ? dead_tmr - 1'b1
                                                   : dead_tmr;
        next_rec = (tick && rec_tmr != TMR_RST) ? rec_tmr - 1'b1
                                                 : rec_tmr;
        next_close = 1'b0;
        next_trip3p = TRIP_3P_CMD;
        ev = '0;
        case (state)
            S_IDLE: begin
                next_trip3p = 1'b0;
                next_cycle = '0;
                if (trip_any && ready) begin
                    if (!act_late && perm && !blocked_in) begin
                        next_one_pole = trip_is_1p;
                        next_cleared = 1'b0;
                        next_state = S_TRIPPED;
                    end else begin
                        ev[IRQ_FINAL] = 1'b1;
                        next_state = S_BLOCKED;
                    end
                end
            end
            S_TRIPPED: begin
                if (pin_s.trip_3p) begin
                    next_one_pole = 1'b0;
                end
                if (blocked_in) begin
                    next_trip3p = one_pole & force3p;
                    ev[IRQ_FINAL] = 1'b1;
                    next_state = S_BLOCKED;
                end else if (!trip_any || any_open) begin
                    next_dead = (one_pole && !pin_s.trip_3p)
                                ? cur.dead_1p : cur.dead_3p;
                    next_state = S_DEAD;
                end
            end
            S_DEAD: begin
                if (!trip_any) begin
                    next_cleared = 1'b1;
                end
                if (blocked_in) begin
                    next_trip3p = one_pole & force3p;
                    ev[IRQ_FINAL] = 1'b1;
                    next_state = S_BLOCKED;
                end else if (cleared && seq_rise) begin
                    ev[IRQ_SEQ] = 1'b1;
                    next_trip3p = 1'b1;
                    next_one_pole = 1'b0;
                    if (seq_3p) begin
                        next_state = S_SEQ_WAIT;
                    end else begin
                        ev[IRQ_FINAL] = 1'b1;
                        next_state = S_BLOCKED;
                    end
                end else if (dead_tmr == TMR_RST && !trip_any) begin
                    next_close = 1'b1;
                    next_rec = cur.reclaim;
                    next_cycle = cycle_cnt + 4'h1;
                    next_trip3p = 1'b0;
                    ev[IRQ_CLOSE] = 1'b1;
                    next_state = S_RECLAIM;
                end
            end
            S_SEQ_WAIT: begin
                // Sequential dead time waits for its own fault to clear
                if (blocked_in) begin
                    ev[IRQ_FINAL] = 1'b1;
                    next_state = S_BLOCKED;
                end else if (!seq_det && !trip_any) begin
                    next_dead = seq_dead;
                    next_cleared = 1'b1;
                    next_state = S_DEAD;
                end
            end
            S_RECLAIM: begin
                if (trip_any) begin
                    next_rec = TMR_RST;
                    if (!last_done && perm && !blocked_in) begin
                        next_one_pole = trip_is_1p;
                        next_cleared = 1'b0;
                        next_state = S_TRIPPED;
                    end else begin
                        ev[IRQ_FINAL] = 1'b1;
                        next_state = S_BLOCKED;
                    end
                end else if (rec_tmr == TMR_RST) begin
                    ev[IRQ_SUCCESS] = 1'b1;
                    next_cycle = '0;
                    next_state = S_IDLE;
                end
            end
            S_BLOCKED: begin
                // Forced trip held until every pole shows open or a release is written
                if (all_open) begin
                    next_trip3p = 1'b0;
                end
                next_cycle = '0;
                if (block_release) begin
                    next_trip3p = 1'b0;
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // Protection uses its not-ready stage when no reclosure can follow
    wire next_not_ready = !reclose_en || (next_state == S_BLOCKED)
        || ((next_state == S_IDLE) && any_open)
        || ((next_state == S_RECLAIM) && (next_cycle >= max_cyc));

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state <= S_IDLE;
            cycle_cnt <= '0;
            one_pole <= 1'b0;
            cleared <= 1'b0;
            dead_tmr <= TMR_RST;
            rec_tmr <= TMR_RST;
            CLOSE_CMD <= 1'b0;
            TRIP_3P_CMD <= 1'b0;
            NOT_READY <= 1'b1;
        end else if (CE) begin
            state <= next_state;
            cycle_cnt <= next_cycle;
            one_pole <= next_one_pole;
            cleared <= next_cleared;
            dead_tmr <= next_dead;
            rec_tmr <= next_rec;
            CLOSE_CMD <= next_close;
            TRIP_3P_CMD <= next_trip3p;
            NOT_READY <= next_not_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts

    // An event in the clearing cycle survives the clear
    wire [IRQ_W-1:0] clr_bits = (wr && adr == REG_IRQ_STAT)
                                ? irq_clr[IRQ_W-1:0] : '0;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            irq_stat <= '0;
        end else if (CE) begin
            irq_stat <= (irq_stat & ~clr_bits) | ev;
        end
    end

    assign IRQ = |(irq_stat & irq_mask);

endmodule : auto_reclose_sequencer

// file: auto_reclose_sequencer_sva.sv
// Port-level assertions for the auto-reclose sequencer
module reclose_checker #(
    parameter int unsigned TICK_CYCLES = 10
) (
    // Clock and control
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    // Register bus
    input wire reclose_pkg::wb_req_t WB_REQ,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Pins and commands
    input wire reclose_pkg::pins_t PINS,
    input wire logic CLOSE_CMD,
    input wire logic TRIP_3P_CMD,
    input wire logic NOT_READY,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    import reclose_pkg::*;
    logic req_new;
    logic trip_seen;
    logic poles_any;
    assign req_new = CE && WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O;
    assign trip_seen = PINS.trip_1p || PINS.trip_3p;
    assign poles_any = PINS.pole_closed != 3'h0;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////
    chk_ack_next: assert property (req_new |=> WB_ACK_O)
        else $error("ack missing after request");
    chk_ack_single: assert property (WB_ACK_O && CE |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(req_new))
        else $error("ack without request");
    chk_unmapped_zero: assert property (req_new && !WB_REQ.we
        && WB_REQ.adr == 8'h14 |=> WB_DAT_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_reset_state: assert property (disable iff (1'b0)
        RST && CE |=> !CLOSE_CMD && !TRIP_3P_CMD && NOT_READY && !IRQ)
        else $error("outputs wrong after reset");
    chk_close_pulse: assert property (CLOSE_CMD |=> !CLOSE_CMD)
        else $error("close command longer than one cycle");
    chk_close_trip_low: assert property (
        CLOSE_CMD |-> !$past(trip_seen, 3))
        else $error("close while trip active");
    chk_trip3p_holds: assert property (
        TRIP_3P_CMD && CE && !WB_REQ.cyc && poles_any && $past(poles_any)
        && $past(poles_any, 2) |=> TRIP_3P_CMD || CLOSE_CMD)
        else $error("three-pole trip dropped with poles closed");
endmodule : reclose_checker

bind auto_reclose_sequencer reclose_checker
    #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .WB_REQ(WB_REQ),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PINS(PINS),
    .CLOSE_CMD(CLOSE_CMD), .TRIP_3P_CMD(TRIP_3P_CMD),
    .NOT_READY(NOT_READY), .IRQ(IRQ));

// file: breaker_model.sv
// Behavioural breaker with per-pole auxiliary contacts
module breaker_model (
    // Clock
    input wire logic REF_CLK,
    // Commands
    input wire logic trip_1p,
    input wire logic trip_any,
    input wire logic close_cmd,
    input wire logic [2:0] stuck_open,
    // Contacts
    output logic [2:0] pole_closed
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] pend = 3'h7;
    logic [2:0] mech = 3'h7;
    // Two-cycle mechanism delay, so contacts lag commands
    always @(posedge REF_CLK) begin
        pend <= close_cmd ? 3'h7 : trip_any ? 3'h0
            : trip_1p ? (pend & 3'h6) : pend;
        mech <= pend;
    end
    assign pole_closed = mech & ~stuck_open;
endmodule : breaker_model

// file: tb_top.sv
// Self-checking bench for the auto-reclose sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import reclose_pkg::*;
    localparam int TICK = 10;
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic CE = 1'b1;
    wb_req_t req = '0;
    logic t1 = 1'b0;
    logic t3 = 1'b0;
    logic pk = 1'b0;
    logic mclose = 1'b0;
    logic [3:0] blk = 4'h0;
    logic [2:0] stuck = 3'h0;
    logic [2:0] pc;
    logic [31:0] rd;
    logic [31:0] dat;
    logic ack, close_cmd, trip3, not_ready, irq;
    logic [31:0] seed = 32'ha283_b24c;
    logic [15:0] d1[4];
    logic [15:0] d3[4];
    logic [7:0] mode[4] = '{8'h01, 8'h21, 8'h41, 8'h11};
    logic [7:0] ra[6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h2C, 8'h14};
    int err_total = 0;
    int total_checks = 0;
    int ncl = 0;
    int n3p = 0;
    int dt, c3, cc;
    pins_t pins;
    assign pins = '{t1, t3, pk, pc, blk};
    auto_reclose_sequencer #(.TICK_CYCLES(TICK)) uut (
        .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .WB_REQ(req),
        .WB_DAT_O(dat), .WB_ACK_O(ack), .PINS(pins),
        .CLOSE_CMD(close_cmd), .TRIP_3P_CMD(trip3),
        .NOT_READY(not_ready), .IRQ(irq));
    breaker_model brk (.REF_CLK(REF_CLK), .trip_1p(t1),
        .trip_any(t3 | trip3), .close_cmd(close_cmd | mclose),
        .stuck_open(stuck), .pole_closed(pc));
    always #50 REF_CLK = ~REF_CLK;
    always @(negedge REF_CLK) begin
        if (close_cmd === 1'b1) ncl++;
        if (trip3 === 1'b1) n3p++;
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Window allows for tick phase and synchroniser latency
    function automatic logic in_win(input int t, input logic [15:0] d);
        return t >= TICK * int'(d) - TICK && t <= TICK * int'(d) + 30;
    endfunction : in_win
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b1, w, a, 4'hF, d};
        do begin
            @(posedge REF_CLK);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat;
        req <= '0;
        @(posedge REF_CLK);
        if (n >= 20) begin
            err_total++;
            summarize();
        end
    endtask : wb
    task automatic fault(input logic p1, input int lim);
        cc = ncl;
        dt = 6;
        if (p1) t1 <= 1'b1;
        else t3 <= 1'b1;
        repeat (6) @(posedge REF_CLK);
        t1 <= 1'b0;
        t3 <= 1'b0;
        while (ncl == cc && dt < lim) begin
            @(posedge REF_CLK);
            dt++;
        end
        @(posedge REF_CLK);
    endtask : fault
    // Release also recloses the breaker by hand
    task automatic rel(input logic [31:0] ctrl);
        wb(1'b1, REG_CTRL, ctrl | 32'h0000_0080);
        mclose <= 1'b1;
        @(posedge REF_CLK);
        mclose <= 1'b0;
        repeat (100) @(posedge REF_CLK);
    endtask : rel
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, ra[i], 32'h0000_0000);
            check("reset reg", rd, 32'h0000_0000);
        end
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        check("reset status", rd, 32'h0000_2001);
        for (int n = 0; n < 4; n++) begin
            seed = xs(seed);
            d3[n] = 16'(5 * n + 1) + 16'(seed[0]);
            d1[n] = 16'(5 * n + 22) + 16'(seed[1]);
            wb(1'b1, 8'(8'h20 + 16 * n), {16'h0000, d1[n]});
            wb(1'b1, 8'(8'h24 + 16 * n), {16'h0000, d3[n]});
            wb(1'b1, 8'(8'h28 + 16 * n), 32'h0000_0008);
            wb(1'b1, 8'(8'h2C + 16 * n), 32'h0003_0000);
        end
        $display("test reset done");
        wb(1'b1, REG_IRQ_MASK, 32'h0000_000F);
        wb(1'b1, REG_CTRL, 32'h0000_000F);
        c3 = ncl;
        for (int k = 0; k < 9; k++) begin
            fault(1'b0, 400);
            check("dead", in_win(dt, d3[k < 4 ? k : 3]), k < 8);
        end
        check("closes", 32'(ncl - c3), 32'h0000_0008);
        check("final", not_ready, 1'b1);
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        check("blocked", rd & 32'h0000_3F3F, 32'h0000_3020);
        check("irq", irq, 1'b1);
        wb(1'b1, REG_IRQ_STAT, 32'h0000_000F);
        check("irq cleared", irq, 1'b0);
        rel(32'h0000_0001);
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        check("released", rd & 32'h0000_103F, 32'h0000_0001);
        $display("test multi-cycle done");
        fault(1'b1, 500);
        check("dead 1p", in_win(dt, d1[0]), 1'b1);
        repeat (8 * TICK + 40) @(posedge REF_CLK);
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        check("success", rd & 32'h0000_003F, 32'h0000_0001);
        wb(1'b0, REG_IRQ_STAT, 32'h0000_0000);
        check("success irq", rd & 32'h0000_0002, 32'h0000_0002);
        fault(1'b1, 500);
        fault(1'b0, 300);
        check("reclaim fault", dt >= 300 && not_ready === 1'b1, 1'b1);
        rel(32'h0000_0001);
        $display("test single-cycle done");
        wb(1'b1, REG_SEQ_DEAD, 32'h0000_0003);
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, REG_CTRL, {24'h00_0000, mode[m]});
            c3 = n3p;
            cc = ncl;
            t1 <= 1'b1;
            repeat (6) @(posedge REF_CLK);
            t1 <= 1'b0;
            repeat (12) @(posedge REF_CLK);
            if (m == 1) pk <= 1'b1;
            else if (m == 3) blk <= 4'h1;
            else t1 <= 1'b1;
            repeat (12) @(posedge REF_CLK);
            t1 <= 1'b0;
            pk <= 1'b0;
            blk <= 4'h0;
            repeat (120) @(posedge REF_CLK);
            check("forced 3p", n3p > c3, 1'b1);
            check("seq close", ncl != cc, m == 2);
            wb(1'b0, REG_STATUS, 32'h0000_0000);
            check("seq block", rd[5], m != 2);
            rel(32'h0000_0001);
            $display("test sequential mode %0d done", m);
        end
        // A trip while frozen must never reach the sequencer
        CE <= 1'b0;
        t3 <= 1'b1;
        repeat (20) @(posedge REF_CLK);
        t3 <= 1'b0;
        CE <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        check("frozen", rd[5:0], 6'h01);
        rel(32'h0000_0001);
        $display("test clock enable done");
        stuck <= 3'h1;
        fault(1'b1, 300);
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        check("no start", rd[5:0] == 6'h01 && dt >= 300, 1'b1);
        stuck <= 3'h0;
        $display("test pole check done");
        summarize();
    end
endmodule : tb_top
